// File: hw/aat_pkg.sv
package aat_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_TIME_NS  = 1000;
	localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W           = 11;
	localparam int         DATA_W           = 8;
	localparam logic [10:0] RX_PWRDN_OFS     = 11'h324;
	localparam logic [10:0] AUX_PWRDN_OFS    = 11'h325;
	localparam logic [10:0] RESULT_UPPER_OFS = 11'h327;
	localparam logic [10:0] RESULT_LOWER_OFS = 11'h328;
	localparam logic [10:0] SRC_SEL_OFS      = 11'h359;
	localparam logic [7:0]  RX_PWRDN_RST     = 8'h00;
	localparam logic [7:0]  AUX_PWRDN_RST    = 8'h00;
	localparam logic [7:0]  SRC_SEL_RST      = 8'h00;

	// ----------------------------------------------------------------
	// Fields and values
	// ----------------------------------------------------------------
	localparam int         ADC_EN_BIT     = 4;
	localparam logic [7:0] ADC_EN_VAL     = 8'h10;
	localparam int         SENSOR_EN_BIT  = 1;
	localparam logic [7:0] SENSOR_EN_VAL  = 8'h02;
	localparam int         SRC_FIELD_LSB  = 2;
	localparam logic [1:0] SRC_TEMP       = 2'h2;
	localparam logic [1:0] SRC_EXT        = 2'h1;
	localparam logic [7:0] SRC_TEMP_VAL   = 8'h08;

	// ----------------------------------------------------------------
	// Temperature conversion, Q8.8 offset and Q16 reciprocal gain
	// ----------------------------------------------------------------
	localparam logic signed [17:0] TEMP_OFS_Q8   = 18'sh02a32;
	localparam logic        [16:0] TEMP_GAIN_Q16 = 17'h0fa3e;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		radio_off_state       = 2'h0,
		radio_idle_on_state   = 2'h1,
		radio_receive_state   = 2'h2,
		radio_transmit_state  = 2'h3
	} aat_radio_e;

	typedef enum logic [1:0] {
		rb_idle     = 2'h0,
		rb_started  = 2'h1,
		rb_low_done = 2'h2
	} aat_rb_e;

endpackage : aat_pkg

// File: hw/aat_ctrl_if.sv
`timescale 1ns/1ps
interface aat_ctrl_if;
	logic        req;
	logic        we;
	logic [10:0] addr;
	logic [7:0]  wdata;
	logic        ack;
	logic [7:0]  rdata;

	modport dev  (input req, input we, input addr, input wdata, output ack, output rdata);
	modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : aat_ctrl_if

// File: hw/aat_device.sv
// Summary of operation
// [RL1] Convert temperature, signal strength or external input.
// [RL2] Each conversion takes about one microsecond.
// [RL3] Result is 8 bits over two readback registers.
// [RL4] Source register picks the converter input.
// [RL5] Receive state forces signal strength as input.
// [RL6] Receive state powers converter without host writes.
// [RL7] Host writes 0x10 to power converter otherwise.
// [RL8] Read upper, lower, upper; low bits then high.
// [RL9] Host enables converter, sensor, then selects sensor.
// [RL10] Writing 0x02 to aux register powers sensor.
// [RL11] Writing 0x08 to source register selects sensor.
// [RL12] Host computes temperature from reading by formula.
// [RL13] Host may calibrate offset at known temperature.
// [RL14] Readback start captures one sample for both parts.
`timescale 1ns/1ps
module aat_device (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	aat_ctrl_if.dev         bus,
	input  wire logic [1:0] radio_state,
	input  wire logic [7:0] temp_level,
	input  wire logic [7:0] sig_level,
	input  wire logic [7:0] ext_level,
	output logic            adc_on,
	output logic            sensor_on,
	output logic [7:0]      conv_result,
	output logic            conv_done
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]      temp_s1;
		logic [7:0]      temp_s2;
		logic [7:0]      sig_s1;
		logic [7:0]      sig_s2;
		logic [7:0]      ext_s1;
		logic [7:0]      ext_s2;
		logic [7:0]      rx_pwrdn;
		logic [7:0]      aux_pwrdn;
		logic [7:0]      src_sel;
		logic [4:0]      cnt;
		logic [2:0]      bit_idx;
		logic [7:0]      hold;
		logic [7:0]      sar;
		logic [7:0]      result;
		logic [7:0]      snap;
		aat_pkg::aat_rb_e phase;
		logic            ack;
		logic [7:0]      rdata;
		logic            adc_on;
		logic            sensor_on;
		logic            done;
	} aat_dev_s;

	aat_dev_s st_ff;
	aat_dev_s nxt_st;

	logic       in_rx;
	logic       adc_pwr;
	logic       sens_pwr;
	logic [1:0] src;
	logic [7:0] sel_level;
	logic [7:0] trial;
	logic       take;
	logic       step_en;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		in_rx = (radio_state == aat_pkg::radio_receive_state);
		adc_pwr = in_rx | st_ff.rx_pwrdn[aat_pkg::ADC_EN_BIT]; // [RL6] [RL7]
		sens_pwr = st_ff.aux_pwrdn[aat_pkg::SENSOR_EN_BIT]; // [RL10]
		src = st_ff.src_sel[aat_pkg::SRC_FIELD_LSB +: 2];
		if (in_rx) begin
			sel_level = st_ff.sig_s2; // [RL5]
		end else if (src == aat_pkg::SRC_TEMP) begin
			sel_level = sens_pwr ? st_ff.temp_s2 : 8'h00; // [RL4] [RL11]
		end else if (src == aat_pkg::SRC_EXT) begin
			sel_level = st_ff.ext_s2; // [RL4]
		end else begin
			sel_level = st_ff.sig_s2; // [RL4]
		end
		trial = st_ff.sar | (8'h01 << st_ff.bit_idx);
		take = bus.req & ~st_ff.ack;
		step_en = st_ff.cnt[0];

		nxt_st.temp_s1 = temp_level;
		nxt_st.temp_s2 = st_ff.temp_s1;
		nxt_st.sig_s1 = sig_level;
		nxt_st.sig_s2 = st_ff.sig_s1;
		nxt_st.ext_s1 = ext_level;
		nxt_st.ext_s2 = st_ff.ext_s1;
		nxt_st.adc_on = adc_pwr;
		nxt_st.sensor_on = sens_pwr;
		nxt_st.done = 1'b0;

		// ------------------------------------------------------------
		// Successive approximation, one bit every second cycle
		// ------------------------------------------------------------
		if (!adc_pwr) begin
			nxt_st.cnt = 5'h00;
		end else if (st_ff.cnt == 5'h00) begin
			nxt_st.hold = sel_level; // [RL1]
			nxt_st.sar = 8'h00;
			nxt_st.bit_idx = 3'h7;
			nxt_st.cnt = 5'h01;
		end else if (st_ff.cnt == 5'(aat_pkg::CONV_CYC - 1)) begin
			nxt_st.result = st_ff.sar; // [RL2]
			nxt_st.done = 1'b1;
			nxt_st.cnt = 5'h00;
		end else begin
			nxt_st.cnt = st_ff.cnt + 5'h01;
			if (step_en && st_ff.cnt < 5'h11) begin
				if (trial <= st_ff.hold) begin
					nxt_st.sar = trial; // [RL1]
				end
				nxt_st.bit_idx = st_ff.bit_idx - 3'h1;
			end
		end

		// ------------------------------------------------------------
		// Register port
		// ------------------------------------------------------------
		nxt_st.ack = take;
		if (take) begin
			nxt_st.rdata = 8'h00;
			if (bus.we) begin
				case (bus.addr)
					aat_pkg::RX_PWRDN_OFS: begin
						nxt_st.rx_pwrdn = bus.wdata; // [RL7]
					end
					aat_pkg::AUX_PWRDN_OFS: begin
						nxt_st.aux_pwrdn = bus.wdata; // [RL10]
					end
					aat_pkg::SRC_SEL_OFS: begin
						nxt_st.src_sel = bus.wdata; // [RL4] [RL11]
					end
					default: begin
						nxt_st.rdata = 8'h00;
					end
				endcase
			end else begin
				case (bus.addr)
					aat_pkg::RX_PWRDN_OFS: begin
						nxt_st.rdata = st_ff.rx_pwrdn;
					end
					aat_pkg::AUX_PWRDN_OFS: begin
						nxt_st.rdata = st_ff.aux_pwrdn;
					end
					aat_pkg::SRC_SEL_OFS: begin
						nxt_st.rdata = st_ff.src_sel;
					end
					aat_pkg::RESULT_UPPER_OFS: begin
						if (st_ff.phase == aat_pkg::rb_low_done) begin
							nxt_st.rdata = {2'h0, st_ff.snap[7:2]}; // [RL3] [RL8]
							nxt_st.phase = aat_pkg::rb_idle;
						end else begin
							nxt_st.snap = st_ff.result; // [RL14]
							nxt_st.phase = aat_pkg::rb_started; // [RL8]
						end
					end
					aat_pkg::RESULT_LOWER_OFS: begin
						nxt_st.rdata = {6'h00, st_ff.snap[1:0]}; // [RL3] [RL8]
						if (st_ff.phase == aat_pkg::rb_started) begin
							nxt_st.phase = aat_pkg::rb_low_done;
						end
					end
					default: begin
						nxt_st.rdata = 8'h00;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{
				temp_s1:   8'h00,
				temp_s2:   8'h00,
				sig_s1:    8'h00,
				sig_s2:    8'h00,
				ext_s1:    8'h00,
				ext_s2:    8'h00,
				rx_pwrdn:  aat_pkg::RX_PWRDN_RST,
				aux_pwrdn: aat_pkg::AUX_PWRDN_RST,
				src_sel:   aat_pkg::SRC_SEL_RST,
				cnt:       5'h00,
				bit_idx:   3'h7,
				hold:      8'h00,
				sar:       8'h00,
				result:    8'h00,
				snap:      8'h00,
				phase:     aat_pkg::rb_idle,
				ack:       1'b0,
				rdata:     8'h00,
				adc_on:    1'b0,
				sensor_on: 1'b0,
				done:      1'b0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.ack     = st_ff.ack;
	assign bus.rdata   = st_ff.rdata;
	assign adc_on      = st_ff.adc_on;
	assign sensor_on   = st_ff.sensor_on;
	assign conv_result = st_ff.result;
	assign conv_done   = st_ff.done;

endmodule : aat_device

// File: hw/aat_host.sv
`timescale 1ns/1ps
module aat_host (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	aat_ctrl_if.host                bus,
	input  wire logic               setup_req,
	input  wire logic               sample_req,
	input  wire logic               cal_req,
	input  wire logic signed [17:0] known_temp_q8,
	output logic                    busy,
	output logic                    done,
	output logic [7:0]              code,
	output logic signed [17:0]      temp_q8
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		h_idle = 2'h0,
		h_wait = 2'h1,
		h_next = 2'h2,
		h_calc = 2'h3
	} aat_hst_e;

	typedef enum logic [1:0] {
		m_setup  = 2'h0,
		m_sample = 2'h1,
		m_cal    = 2'h2
	} aat_mode_e;

	typedef struct packed {
		aat_hst_e          state;
		aat_mode_e         mode;
		logic [1:0]        idx;
		logic              req;
		logic              we;
		logic [10:0]       addr;
		logic [7:0]        wdata;
		logic [1:0]        lo;
		logic [7:0]        code;
		logic signed [17:0] temp;
		logic signed [17:0] corr;
		logic              busy;
		logic              done;
	} aat_hst_s;

	aat_hst_s st_ff;
	aat_hst_s nxt_st;

	logic [19:0]        op;
	logic signed [17:0] diff;
	logic signed [35:0] prod;
	logic signed [17:0] raw;

	// Step list: power converter, power sensor, select sensor; or the readback reads.
	function automatic logic [19:0] aat_op(input aat_mode_e m, input logic [1:0] i);
		logic [19:0] r;
		r = {1'b0, aat_pkg::RESULT_UPPER_OFS, 8'h00};
		if (m == m_setup) begin
			case (i)
				2'h0: r = {1'b1, aat_pkg::RX_PWRDN_OFS, aat_pkg::ADC_EN_VAL}; // [RL7] [RL9]
				2'h1: r = {1'b1, aat_pkg::AUX_PWRDN_OFS, aat_pkg::SENSOR_EN_VAL}; // [RL10]
				default: r = {1'b1, aat_pkg::SRC_SEL_OFS, aat_pkg::SRC_TEMP_VAL}; // [RL11]
			endcase
		end else if (i == 2'h1) begin
			r = {1'b0, aat_pkg::RESULT_LOWER_OFS, 8'h00}; // [RL8]
		end
		return r;
	endfunction : aat_op

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		op = aat_op(st_ff.mode, st_ff.idx + 2'h1);
		diff = $signed({2'h0, st_ff.code, 8'h00}) - aat_pkg::TEMP_OFS_Q8;
		prod = diff * $signed({1'b0, aat_pkg::TEMP_GAIN_Q16});
		raw = prod[33:16]; // [RL12]
		case (st_ff.state)
			h_idle: begin
				if (setup_req || sample_req || cal_req) begin
					if (setup_req) begin
						nxt_st.mode = m_setup;
					end else if (sample_req) begin
						nxt_st.mode = m_sample;
					end else begin
						nxt_st.mode = m_cal;
					end
					{nxt_st.we, nxt_st.addr, nxt_st.wdata} = aat_op(nxt_st.mode, 2'h0);
					nxt_st.idx = 2'h0;
					nxt_st.req = 1'b1;
					nxt_st.busy = 1'b1;
					nxt_st.state = h_wait;
				end
			end
			h_wait: begin
				if (bus.ack) begin
					nxt_st.req = 1'b0;
					if (st_ff.mode != m_setup && st_ff.idx == 2'h1) begin
						nxt_st.lo = bus.rdata[1:0]; // [RL8]
					end
					if (st_ff.idx == 2'h2) begin
						if (st_ff.mode == m_setup) begin
							nxt_st.busy = 1'b0;
							nxt_st.done = 1'b1;
							nxt_st.state = h_idle;
						end else begin
							nxt_st.code = {bus.rdata[5:0], st_ff.lo}; // [RL8]
							nxt_st.state = h_calc;
						end
					end else begin
						{nxt_st.we, nxt_st.addr, nxt_st.wdata} = op;
						nxt_st.idx = st_ff.idx + 2'h1;
						nxt_st.state = h_next;
					end
				end
			end
			h_next: begin
				nxt_st.req = 1'b1;
				nxt_st.state = h_wait;
			end
			h_calc: begin
				if (st_ff.mode == m_cal) begin
					nxt_st.corr = known_temp_q8 - raw; // [RL13]
					nxt_st.temp = known_temp_q8;
				end else begin
					nxt_st.temp = raw + st_ff.corr; // [RL12]
				end
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
				nxt_st.state = h_idle;
			end
			default: begin
				nxt_st.state = h_idle;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{
				state: h_idle,
				mode:  m_setup,
				idx:   2'h0,
				req:   1'b0,
				we:    1'b0,
				addr:  11'h000,
				wdata: 8'h00,
				lo:    2'h0,
				code:  8'h00,
				temp:  18'sh00000,
				corr:  18'sh00000,
				busy:  1'b0,
				done:  1'b0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bus.req   = st_ff.req;
	assign bus.we    = st_ff.we;
	assign bus.addr  = st_ff.addr;
	assign bus.wdata = st_ff.wdata;
	assign busy      = st_ff.busy;
	assign done      = st_ff.done;
	assign code      = st_ff.code;
	assign temp_q8   = st_ff.temp;

endmodule : aat_host

// File: verif/aat_assertions.sv
`timescale 1ns/1ps
module aat_assertions (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        req,
	input wire logic        we,
	input wire logic [10:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        ack,
	input wire logic [7:0]  rdata
);
	// --------------------------------
	// Readback phase tracker
	// --------------------------------
	logic rd_ack;
	logic lo_ff;
	logic nxt_lo;
	logic up_a;
	logic lo_a;
	assign rd_ack = ack && !we;
	assign up_a = addr == aat_pkg::RESULT_UPPER_OFS;
	assign lo_a = addr == aat_pkg::RESULT_LOWER_OFS;
	always_comb begin
		nxt_lo = lo_ff;
		if (rd_ack && lo_a) nxt_lo = 1'b1;
		if (rd_ack && up_a) nxt_lo = 1'b0;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) lo_ff <= 1'b0;
		else lo_ff <= nxt_lo;
	end
	// --------------------------------
	// Properties
	// --------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	property p_ack_next;
		req && !ack |=> ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack");
	property p_ack_pulse;
		ack |=> !ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		ack |-> $past(req) && !$past(ack);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_req_hold;
		req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request moved");
	property p_req_drop;
		ack |=> !req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("req held");
	property p_start_zero;
		rd_ack && up_a && !lo_ff |-> rdata == 8'h00;
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("start not zero");
	property p_low_fmt;
		rd_ack && lo_a |-> rdata[7:2] == 6'h00;
	endproperty
	a_low_fmt: assert property (p_low_fmt) else $error("low format");
	property p_high_fmt;
		rd_ack && up_a && lo_ff |-> rdata[7:6] == 2'h0;
	endproperty
	a_high_fmt: assert property (p_high_fmt) else $error("high format");
	property p_wr_vals;
		req && we |-> (addr == aat_pkg::RX_PWRDN_OFS && wdata == 8'h10)
			|| (addr == aat_pkg::AUX_PWRDN_OFS && wdata == 8'h02)
			|| (addr == aat_pkg::SRC_SEL_OFS && wdata == 8'h08);
	endproperty
	a_wr_vals: assert property (p_wr_vals) else $error("bad write");
endmodule : aat_assertions

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic               sys_clk;
	logic               rst;
	logic               setup_req;
	logic               sample_req;
	logic               cal_req;
	logic signed [17:0] known_temp_q8;
	logic [1:0]         radio_state;
	logic [7:0]         temp_level;
	logic [7:0]         sig_level;
	logic [7:0]         ext_level;
	logic               adc_on;
	logic               sensor_on;
	logic [7:0]         conv_result;
	logic               conv_done;
	logic               busy;
	logic               done;
	logic [7:0]         code;
	logic signed [17:0] temp_q8;
	logic               tgl;
	logic [7:0]         temp_set;
	int                 n_mismatch;
	int                 n_checks;
	int                 n_cyc;
	longint             corr;
	aat_ctrl_if bus_if ();
	aat_device u_aat_device (.sys_clk(sys_clk), .rst(rst), .bus(bus_if),
		.radio_state(radio_state), .temp_level(temp_level), .sig_level(sig_level),
		.ext_level(ext_level), .adc_on(adc_on), .sensor_on(sensor_on),
		.conv_result(conv_result), .conv_done(conv_done));
	aat_host u_aat_host (.sys_clk(sys_clk), .rst(rst), .bus(bus_if),
		.setup_req(setup_req), .sample_req(sample_req), .cal_req(cal_req),
		.known_temp_q8(known_temp_q8), .busy(busy), .done(done), .code(code),
		.temp_q8(temp_q8));
	aat_assertions u_aat_assertions (.sys_clk(sys_clk), .rst(rst), .req(bus_if.req),
		.we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
		.rdata(bus_if.rdata));
	// --------------------------------
	// Clock, timeout and level toggler
	// --------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		n_cyc++;
		temp_level <= (tgl && n_cyc[0]) ? ~temp_set : temp_set;
	end
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cmd(input int k);
		int i;
		@(posedge sys_clk);
		setup_req <= k == 0;
		sample_req <= k == 1;
		cal_req <= k == 2;
		@(posedge sys_clk);
		setup_req <= 1'b0;
		sample_req <= 1'b0;
		cal_req <= 1'b0;
		@(negedge sys_clk);
		chk("busy", 18'(busy), 18'h1);
		for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge sys_clk);
		chk("done", 18'(done), 18'h1);
		chk("busy", 18'(busy), 18'h0);
	endtask : cmd
	function automatic longint texp(input longint c);
		return (((c * 256 - 10802) * 64062) >>> 16) + corr;
	endfunction : texp
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// --------------------------------
	// Tests
	// --------------------------------
	task automatic run_tests;
		int i;
		int n;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk("adc_on", 18'(adc_on), 18'h0);
		chk("sensor_on", 18'(sensor_on), 18'h0);
		$display("test reset done");
		@(posedge sys_clk) radio_state <= aat_pkg::radio_receive_state;
		repeat (10) @(negedge sys_clk);
		chk("adc_on", 18'(adc_on), 18'h1);
		@(posedge sys_clk) radio_state <= aat_pkg::radio_off_state;
		repeat (10) @(negedge sys_clk);
		chk("adc_on", 18'(adc_on), 18'h0);
		$display("test power done");
		cmd(0);
		chk("adc_on", 18'(adc_on), 18'h1);
		chk("sensor_on", 18'(sensor_on), 18'h1);
		repeat (50) @(posedge sys_clk);
		cmd(1);
		chk("code", 18'(code), 18'h0a5);
		chk("temp", temp_q8, 18'(texp(165)));
		$display("test temperature done");
		for (i = 0; i < 40 && conv_done !== 1'b1; i++) @(negedge sys_clk);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (conv_done !== 1'b1 && n < 40);
		chk("period", 18'(n), 18'(aat_pkg::CONV_CYC));
		chk("result", 18'(conv_result), 18'h0a5);
		$display("test conversion done");
		cmd(2);
		chk("cal_temp", temp_q8, known_temp_q8);
		corr = 6400 - texp(165);
		@(posedge sys_clk);
		temp_set <= 8'h60;
		radio_state <= aat_pkg::radio_transmit_state;
		repeat (50) @(posedge sys_clk);
		cmd(1);
		chk("code", 18'(code), 18'h060);
		chk("temp", temp_q8, 18'(texp(96)));
		$display("test calibration done");
		@(posedge sys_clk) radio_state <= aat_pkg::radio_receive_state;
		repeat (50) @(posedge sys_clk);
		cmd(1);
		chk("code", 18'(code), 18'h03c);
		$display("test receive done");
		@(posedge sys_clk);
		radio_state <= aat_pkg::radio_off_state;
		temp_set <= 8'hfc;
		tgl <= 1'b1;
		repeat (50) @(posedge sys_clk);
		for (i = 0; i < 8; i++) begin
			repeat (i * 3 + 1) @(posedge sys_clk);
			cmd(1);
			chk("same", 18'(code == 8'hfc || code == 8'h03), 18'h1);
		end
		$display("test snapshot done");
	endtask : run_tests
	initial begin
		{rst, setup_req, sample_req, cal_req, tgl} = 5'h10;
		{n_mismatch, n_checks, corr} = 0;
		known_temp_q8 = 18'sh01900;
		radio_state = aat_pkg::radio_off_state;
		temp_set = 8'ha5;
		sig_level = 8'h3c;
		ext_level = 8'h5a;
		fork
			run_tests();
			begin
				wait (n_cyc >= 4000);
				n_mismatch++;
			end
		join_any
		close_out();
	end
endmodule : testbench
